// File: core/upfc_function_control.sv
// Operation
// RULE1 - Read at 04h-06h; write, set, clear addresses
// RULE2 - Set ORs byte; clear zeroes masked bits
// RULE3 - Bit 6 active-low suspend, resets to one
// RULE4 - Low power keeps FS receiver, comparators, pins
// RULE5 - Link asserts stop signal to leave low power
// RULE6 - Leaving low power restores suspend bit to one
// RULE7 - Bit 5 raises direction, resets core only
// RULE8 - Reset done: drop direction, clear, send status
// RULE9 - Link stays off bus until direction drops
// RULE10 - Bits 4-3 pick transmit encoding style
// RULE11 - Code 11b drops auto SYNC/EOP, high speed
// RULE12 - Bit 2 steers pull-up and HS terminations
// RULE13 - Bits 1-0 pick HS, FS, LS transceiver
// RULE14 - Code 11b sends LS through FS preamble
// RULE15 - Reserved bit 7 always reads zero
`timescale 1ns/1ps

module upfc_function_control
  import upfc_pkg::*;
#(
  parameter int CORE_RESET_CYCLES = UPFC_CORE_RESET_CYCLES  // Core reset span
) (
  // System clock domain
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Link clock domain, pins toward the link controller
  input  wire logic       clk_link,
  input  wire logic [7:0] link_data_in,
  output logic      [7:0] link_data_out,
  output logic            link_data_oe,
  output logic            link_dir,
  output logic            link_nxt,
  input  wire logic       link_stp,
  // Pull-down controls held elsewhere on this clock
  input  wire logic       plus_line_pulldown_enable,
  input  wire logic       minus_line_pulldown_enable,
  // Core and analog controls, system clock domain
  output logic            core_reset_n,
  output logic            low_power_active,
  output logic            analog_power_enable,
  output logic            fs_receiver_enable,
  output logic            otg_comparator_enable,
  output logic            hs_transceiver_enable,
  output logic            fs_transceiver_enable,
  output logic            ls_transceiver_enable,
  output logic            fs_preamble_enable,
  output logic            tx_non_driving,
  output logic            tx_stuff_nrzi_enable,
  output logic            tx_auto_sync_eop,
  output logic            fs_pullup_enable,
  output logic            hs_termination_enable
);

  // Counter must be able to run at least one cycle
  if (CORE_RESET_CYCLES < 1 || CORE_RESET_CYCLES > 65535) begin : g_chk
    $error("CORE_RESET_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side state machine

  typedef enum logic [2:0] {
    UPFC_IDLE,      // Waiting for a command
    UPFC_WR_DATA,   // Write accepted, waiting for data and stop
    UPFC_RD_TURN,   // Direction raised, bus turnaround
    UPFC_RD_DATA,   // Driving read data
    UPFC_RST_WAIT,  // Core reset running, direction held high
    UPFC_RX_TURN,   // Turnaround before the status byte
    UPFC_RX_DATA    // Driving the status byte
  } upfc_state_t;

  upfc_state_t state_reg;       // Current link state
  upfc_state_t state_next;      // Next link state
  logic [7:0]  ctrl_reg;        // The function control register
  logic [7:0]  ctrl_next;       // Its next value
  logic [5:0]  addr_reg;        // Address of the command in progress
  logic [5:0]  addr_next;
  logic [7:0]  wdata_reg;       // Last byte seen during a write
  logic [7:0]  wdata_next;
  logic [7:0]  dout_reg;        // Data driven toward the link
  logic [7:0]  dout_next;
  logic        oe_reg;          // Drive enable for the data pins
  logic        oe_next;
  logic        rst_req_tgl_reg; // Toggles once per core reset request
  logic        rst_req_tgl_next;
  logic        done_s1_reg;     // First stage, reset done toggle
  logic        done_s2_reg;     // Second stage
  logic        done_s3_reg;     // Edge detect history
  logic        done_tgl_reg;    // Toggles when the core reset ends
  logic [7:0]  xfer_reg;        // Register copy offered to the core side
  logic        xfer_tgl_reg;    // Toggles when a fresh copy is offered
  logic        ack_s1_reg;      // First stage, copy acknowledge
  logic        ack_s2_reg;      // Second stage
  logic        ack_tgl_reg;     // Core side: toggles once a copy is taken

  // Decoding used for both reads and writes
  function automatic logic upfc_addr_hit(input logic [5:0] a);
    upfc_addr_hit = (a == UPFC_FUNC_CTRL_WR) || (a == UPFC_FUNC_CTRL_SET) ||
                    (a == UPFC_FUNC_CTRL_CLR);
  endfunction

  // Command decode on the incoming bus
  wire [1:0] cmd_kind   = link_data_in[7:6];
  wire [5:0] cmd_addr   = link_data_in[5:0];
  wire       suspended  = ~ctrl_reg[UPFC_LOWPWR_BIT];
  wire       cmd_valid  = (state_reg == UPFC_IDLE) && !link_stp &&
                          !suspended;
  wire       cmd_write  = cmd_valid && (cmd_kind == UPFC_CMD_REG_WR);
  wire       cmd_read   = cmd_valid && (cmd_kind == UPFC_CMD_REG_RD);
  // Stop while suspended is the wake request
  wire       wake_req   = (state_reg == UPFC_IDLE) && suspended && link_stp;
  // Write completes on stop, with the byte from the cycle before
  wire       wr_commit  = (state_reg == UPFC_WR_DATA) && link_stp;
  wire       wr_hit     = wr_commit && upfc_addr_hit(addr_reg);
  // Reset done seen as a toggle edge after the synchroniser
  wire       rst_done   = done_s2_reg ^ done_s3_reg;

  // Value produced by a write, set or clear
  wire [7:0] wr_value =
    (addr_reg == UPFC_FUNC_CTRL_SET) ? (ctrl_reg | wdata_reg) :   // RULE2
    (addr_reg == UPFC_FUNC_CTRL_CLR) ? (ctrl_reg & ~wdata_reg) :  // RULE2
                                       wdata_reg;                 // RULE1
  // Reserved bit never stores a one
  wire [7:0] wr_masked  = wr_value & UPFC_WRITABLE_MASK;          // RULE15
  wire       starts_rst = wr_hit && wr_masked[UPFC_RESET_BIT];

  // Next-state and register update for the link side
  always_comb begin
    state_next       = state_reg;
    ctrl_next        = ctrl_reg;
    addr_next        = addr_reg;
    wdata_next       = wdata_reg;
    dout_next        = dout_reg;
    oe_next          = 1'b0;
    rst_req_tgl_next = rst_req_tgl_reg;
    case (state_reg)
      UPFC_IDLE: begin
        if (wake_req) begin
          // Wake restores powered state without a link write
          ctrl_next[UPFC_LOWPWR_BIT] = 1'b1;                      // RULE6
        end else if (cmd_write || cmd_read) begin
          addr_next  = cmd_addr;
          state_next = cmd_write ? UPFC_WR_DATA : UPFC_RD_TURN;
        end
      end
      UPFC_WR_DATA: begin
        if (link_stp) begin
          if (wr_hit) begin
            ctrl_next = wr_masked;                                // RULE1
          end
          // Direction goes high at once while the core resets
          state_next = starts_rst ? UPFC_RST_WAIT : UPFC_IDLE;    // RULE7
          if (starts_rst) begin
            rst_req_tgl_next = ~rst_req_tgl_reg;                  // RULE7
          end
        end else begin
          wdata_next = link_data_in;
        end
      end
      UPFC_RD_TURN: begin
        // Any address in the window returns the same register
        dout_next  = upfc_addr_hit(addr_reg) ? ctrl_reg : 8'h00;  // RULE1
        oe_next    = 1'b1;
        state_next = UPFC_RD_DATA;
      end
      UPFC_RD_DATA: begin
        state_next = UPFC_IDLE;
      end
      UPFC_RST_WAIT: begin
        // Link is off the bus until direction drops             // RULE9
        if (rst_done) begin
          ctrl_next[UPFC_RESET_BIT] = 1'b0;                       // RULE8
          state_next = UPFC_RX_TURN;                              // RULE8
        end
      end
      UPFC_RX_TURN: begin
        // Direction falls for a cycle, then rises for the status
        dout_next  = UPFC_RXCMD_IDLE;                             // RULE8
        oe_next    = 1'b1;
        state_next = UPFC_RX_DATA;
      end
      UPFC_RX_DATA: begin
        state_next = UPFC_IDLE;
      end
      default: begin
        state_next = UPFC_IDLE;
      end
    endcase
  end

  // Link side registers
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= UPFC_IDLE;
      ctrl_reg        <= UPFC_FUNC_CTRL_RST;                      // RULE3
      addr_reg        <= 6'h00;
      wdata_reg       <= 8'h00;
      dout_reg        <= 8'h00;
      oe_reg          <= 1'b0;
      rst_req_tgl_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      ctrl_reg        <= ctrl_next;
      addr_reg        <= addr_next;
      wdata_reg       <= wdata_next;
      dout_reg        <= dout_next;
      oe_reg          <= oe_next;
      rst_req_tgl_reg <= rst_req_tgl_next;
    end
  end

  // Reset done toggle brought into the link domain
  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end else begin
      done_s1_reg <= done_tgl_reg;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end

  // Offer a still copy of the register to the core side; a new copy
  // waits until the last one is acknowledged, so it never moves mid-read
  wire xfer_free = (xfer_tgl_reg == ack_s2_reg);
  wire xfer_load = xfer_free && (xfer_reg != ctrl_reg);

  always_ff @(posedge clk_link or negedge nrst) begin
    if (!nrst) begin
      xfer_reg     <= UPFC_FUNC_CTRL_RST;
      xfer_tgl_reg <= 1'b0;
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      if (xfer_load) begin
        xfer_reg     <= ctrl_reg;
        xfer_tgl_reg <= ~xfer_tgl_reg;
      end
    end
  end

  // Pin drive: for reads the data pins turn on one edge after direction rises; for the status byte, on the same edge
  assign link_dir      = (state_reg == UPFC_RD_TURN) ||
                         (state_reg == UPFC_RD_DATA) ||
                         (state_reg == UPFC_RST_WAIT) ||           // RULE7
                         (state_reg == UPFC_RX_DATA);              // RULE8
  assign link_nxt      = cmd_write || cmd_read;
  assign link_data_out = dout_reg;
  assign link_data_oe  = oe_reg && link_dir;

  ////////////////////////////////////////////////////////////////////////////
  // System side

  // The core side takes the held copy only after its offer toggle has
  // crossed, so all eight bits arrive together and never mix
  logic       xtgl_s1_reg;   // First stage, copy offer toggle
  logic       xtgl_s2_reg;   // Second stage
  logic [7:0] ctrl_s2_reg;   // Control byte as the core sees it
  logic       req_s1_reg;    // First stage, reset request toggle
  logic       req_s2_reg;
  logic       req_s3_reg;
  logic       done_tgl_next;
  logic       busy_reg;      // Core reset in progress
  logic       busy_next;
  logic [15:0] cnt_reg;      // Remaining core reset cycles
  logic [15:0] cnt_next;

  // Synchronisers from the link domain
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      xtgl_s1_reg <= 1'b0;
      xtgl_s2_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      ctrl_s2_reg <= UPFC_FUNC_CTRL_RST;
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
      req_s3_reg  <= 1'b0;
    end else begin
      xtgl_s1_reg <= xfer_tgl_reg;
      xtgl_s2_reg <= xtgl_s1_reg;
      // Copy stays still on the link side while the offer is unanswered
      if (xtgl_s2_reg != ack_tgl_reg) begin
        ctrl_s2_reg <= xfer_reg;
        ack_tgl_reg <= xtgl_s2_reg;
      end
      req_s1_reg  <= rst_req_tgl_reg;
      req_s2_reg  <= req_s1_reg;
      req_s3_reg  <= req_s2_reg;
    end
  end

  wire rst_start = req_s2_reg ^ req_s3_reg;
  wire cnt_last  = busy_reg && (cnt_reg == 16'h0001);

  // Core reset timer
  always_comb begin
    busy_next     = busy_reg;
    cnt_next      = cnt_reg;
    done_tgl_next = done_tgl_reg;
    if (rst_start) begin
      busy_next = 1'b1;                                           // RULE7
      cnt_next  = CORE_RESET_CYCLES[15:0];
    end else if (cnt_last) begin
      busy_next     = 1'b0;
      done_tgl_next = ~done_tgl_reg;                              // RULE8
    end else if (busy_reg) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg     <= 1'b0;
      cnt_reg      <= 16'h0000;
      done_tgl_reg <= 1'b0;
    end else begin
      busy_reg     <= busy_next;
      cnt_reg      <= cnt_next;
      done_tgl_reg <= done_tgl_next;
    end
  end

  // Field views of the synchronised register
  wire [1:0] enc   = ctrl_s2_reg[UPFC_ENC_MSB:UPFC_ENC_LSB];
  wire [1:0] speed = ctrl_s2_reg[UPFC_SPEED_MSB:UPFC_SPEED_LSB];
  wire       term  = ctrl_s2_reg[UPFC_TERM_BIT];
  wire       lowp  = ~ctrl_s2_reg[UPFC_LOWPWR_BIT];               // RULE3
  wire       host  = plus_line_pulldown_enable &&
                     minus_line_pulldown_enable;

  // Core reset and power; low power leaves FS receiver, comparators, fs_pullup_enable and fs_preamble_enable ungated
  assign core_reset_n          = ~busy_reg;                       // RULE7
  assign low_power_active      = lowp;                            // RULE4
  assign analog_power_enable   = ~lowp;                           // RULE4
  assign fs_receiver_enable    = 1'b1;                            // RULE4
  assign otg_comparator_enable = 1'b1;                            // RULE4

  // Transceiver choice
  assign hs_transceiver_enable = ~lowp && (speed == UPFC_SPEED_HS); // RULE13
  assign fs_transceiver_enable = ~lowp && ((speed == UPFC_SPEED_FS) ||
                                 (speed == UPFC_SPEED_LS_PRE));     // RULE14
  assign ls_transceiver_enable = ~lowp && (speed == UPFC_SPEED_LS); // RULE13
  assign fs_preamble_enable    = speed == UPFC_SPEED_LS_PRE;        // RULE14

  // Transmit encoding
  assign tx_non_driving       = enc == UPFC_ENC_NODRIVE;          // RULE10
  assign tx_stuff_nrzi_enable = enc != UPFC_ENC_RAW;              // RULE10
  assign tx_auto_sync_eop     = enc != UPFC_ENC_NOFRAME;          // RULE11

  // Terminations: host pull-downs suppress the device pull-up, and
  // non-driving mode releases the high-speed terminations
  assign fs_pullup_enable      = term && !host &&
                                 (speed != UPFC_SPEED_HS) &&
                                 (enc != UPFC_ENC_NODRIVE);       // RULE12
  assign hs_termination_enable = !term && ~lowp &&
                                 (speed == UPFC_SPEED_HS) &&
                                 (enc != UPFC_ENC_NODRIVE);       // RULE12

endmodule

// File: inc/upfc_pkg.sv
// Shared constants for the transceiver function control block
package upfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses on the link bus
  localparam logic [5:0] UPFC_FUNC_CTRL_WR  = 6'h04;  // Plain write
  localparam logic [5:0] UPFC_FUNC_CTRL_SET = 6'h05;  // OR in bus byte
  localparam logic [5:0] UPFC_FUNC_CTRL_CLR = 6'h06;  // Clear masked bits

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int UPFC_RSVD_BIT    = 7;   // Reserved, reads zero
  localparam int UPFC_LOWPWR_BIT  = 6;   // Active-low suspend control
  localparam int UPFC_RESET_BIT   = 5;   // Self-clearing core reset
  localparam int UPFC_ENC_MSB     = 4;   // Transmit encoding select, top
  localparam int UPFC_ENC_LSB     = 3;   // Transmit encoding select, bottom
  localparam int UPFC_TERM_BIT    = 2;   // Termination choice
  localparam int UPFC_SPEED_MSB   = 1;   // Speed select, top
  localparam int UPFC_SPEED_LSB   = 0;   // Speed select, bottom

  // Reset value: powered, speed select full speed, all else zero
  localparam logic [7:0] UPFC_FUNC_CTRL_RST = 8'h41;
  // Bits that may hold a one (reserved bit is kept clear)
  localparam logic [7:0] UPFC_WRITABLE_MASK = 8'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit command prefixes on the link data bus
  localparam logic [1:0] UPFC_CMD_REG_WR = 2'h2;  // Register write
  localparam logic [1:0] UPFC_CMD_REG_RD = 2'h3;  // Register read

  // Status byte sent after the core reset finishes
  localparam logic [7:0] UPFC_RXCMD_IDLE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Encoding and speed codes
  localparam logic [1:0] UPFC_ENC_NORMAL   = 2'h0;  // Normal operation
  localparam logic [1:0] UPFC_ENC_NODRIVE  = 2'h1;  // Non-driving
  localparam logic [1:0] UPFC_ENC_RAW      = 2'h2;  // No stuffing, no NRZI
  localparam logic [1:0] UPFC_ENC_NOFRAME  = 2'h3;  // No auto SYNC and EOP
  localparam logic [1:0] UPFC_SPEED_HS     = 2'h0;  // High speed
  localparam logic [1:0] UPFC_SPEED_FS     = 2'h1;  // Full speed
  localparam logic [1:0] UPFC_SPEED_LS     = 2'h2;  // Low speed
  localparam logic [1:0] UPFC_SPEED_LS_PRE = 2'h3;  // Low speed via preamble

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int UPFC_CLK_SYS_MHZ       = 50;    // System clock rate
  localparam int UPFC_CORE_RESET_NS     = 200;   // Least core reset time
  localparam int UPFC_CORE_RESET_CYCLES =
    (UPFC_CORE_RESET_NS * UPFC_CLK_SYS_MHZ + 999) / 1000;

endpackage

// File: tb/testbench.sv
`timescale 1ns/1ps

module testbench
  import upfc_pkg::*;
;
  logic clk_sys = 1'b0, clk_link = 1'b0, nrst = 1'b0;
  logic plus_line_pulldown_enable = 1'b0, minus_line_pulldown_enable = 1'b0;
  logic [7:0] link_data_in, link_data_out, rd;
  logic link_data_oe, link_dir, link_nxt, link_stp, core_reset_n;
  logic low_power_active, analog_power_enable, fs_receiver_enable;
  logic otg_comparator_enable, hs_transceiver_enable, fs_preamble_enable;
  logic fs_transceiver_enable, ls_transceiver_enable, tx_non_driving;
  logic tx_stuff_nrzi_enable, tx_auto_sync_eop, fs_pullup_enable;
  logic hs_termination_enable;
  int   checks = 0, miscompares = 0, rst_lows = 0;
  bit   ok;
  // Output groups compared as one byte
  wire logic [7:0] power_vec = {1'b0, hs_transceiver_enable,
    fs_transceiver_enable, ls_transceiver_enable, low_power_active,
    analog_power_enable, fs_receiver_enable, otg_comparator_enable};
  wire logic [3:0] speed_vec = {hs_transceiver_enable,
    fs_transceiver_enable, ls_transceiver_enable, fs_preamble_enable};
  wire logic [2:0] enc_vec = {tx_non_driving, tx_stuff_nrzi_enable,
    tx_auto_sync_eop};
  wire logic [1:0] term_vec = {fs_pullup_enable, hs_termination_enable};

  // Short core reset keeps the run brief
  upfc_function_control #(.CORE_RESET_CYCLES(3)) i_upfc_function_control (.*);
  upfc_link_model i_upfc_link_model (.*);

  always #10 clk_sys = ~clk_sys;
  // Period not a multiple of the system clock, so rising edges never meet
  always #24 clk_link = ~clk_link;
  always @(posedge clk_sys) if (core_reset_n === 1'b0) rst_lows++;

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_upfc_link_model.reg_write(a, d, ok);
    check("write taken", {7'h00, ok}, 8'h01);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    i_upfc_link_model.reg_read(a, rd, ok);
    check("read taken", {7'h00, ok}, 8'h01);
    check("register", rd, exp);
  endtask
  // Lets the control byte cross its synchroniser
  task automatic settle();
    repeat (12) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_dir(input logic v);
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_link);
      #1;
      if (link_dir === v) break;
    end
    check("direction", {7'h00, link_dir}, {7'h00, v});
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 nrst = 1'b1;
    settle();
    check("power", power_vec, 8'h27);
    check("encoding", {5'h00, enc_vec}, 8'h03);
    for (int a = 4; a < 7; a++) rd_chk(6'(a), UPFC_FUNC_CTRL_RST);
    // Every encoding and speed code; no auto SYNC/EOP only at high speed
    for (int i = 0; i < 4; i++) begin
      wr(UPFC_FUNC_CTRL_WR, {3'b110, 2'(i), 1'b0, 2'(3 - i)});
      rd_chk(UPFC_FUNC_CTRL_WR, {3'b010, 2'(i), 1'b0, 2'(3 - i)});
      settle();
      check("encoding", {5'h00, enc_vec},
            {5'h00, i == 1, i != 2, i != 3});
      check("speed", {4'h0, speed_vec},
            {4'h0, i == 3, (i == 2 || i == 0), i == 1, i == 0});
      check("termination", {6'h00, term_vec}, {7'h00, i == 3});
    end
    wr(UPFC_FUNC_CTRL_WR, 8'h41);
    wr(UPFC_FUNC_CTRL_SET, 8'h84);
    rd_chk(UPFC_FUNC_CTRL_CLR, 8'h45);
    wr(UPFC_FUNC_CTRL_CLR, 8'h01);
    rd_chk(UPFC_FUNC_CTRL_WR, 8'h44);
    wr(UPFC_FUNC_CTRL_SET, 8'h01);
    wr(6'h07, 8'h00);
    rd_chk(6'h07, 8'h00);
    rd_chk(UPFC_FUNC_CTRL_SET, 8'h45);
    for (int p = 0; p < 4; p++) begin
      settle();
      plus_line_pulldown_enable = p[0];
      minus_line_pulldown_enable = p[1];
      settle();
      check("pull-up", {6'h00, term_vec}, {6'h00, p != 3, 1'b0});
    end
    // Core reset: bus held, span counted, status byte, bit cleared
    rst_lows = 0;
    wr(UPFC_FUNC_CTRL_SET, 8'h20);
    wait_dir(1'b0);
    check("core reset span", 8'(rst_lows), 8'h03);
    wait_dir(1'b1);
    check("status", link_data_out, UPFC_RXCMD_IDLE);
    check("status drive", {7'h00, link_data_oe}, 8'h01);
    wait_dir(1'b0);
    rd_chk(UPFC_FUNC_CTRL_WR, 8'h45);
    // Suspend, a command that must be ignored, then wake by stop
    wr(UPFC_FUNC_CTRL_CLR, 8'h40);
    settle();
    check("power", power_vec, 8'h0B);
    i_upfc_link_model.wait_idle(ok);
    i_upfc_link_model.send_cmd(8'hC4, 4, ok);
    check("refused", {7'h00, ok}, 8'h00);
    i_upfc_link_model.wake();
    settle();
    check("power", power_vec, 8'h27);
    rd_chk(UPFC_FUNC_CTRL_WR, 8'h45);
    finish_test();
  end

  // Tests need about 8 us; this is far beyond that
  initial begin
    #300000;
    miscompares++;
    finish_test();
  end
endmodule

// File: tb/upfc_checker.sv
`timescale 1ns/1ps

module upfc_checker #(
  parameter int CORE_RESET_CYCLES = 10  // Core reset span
) (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       clk_link,
  input wire logic [7:0] link_data_in,
  input wire logic [7:0] link_data_out,
  input wire logic       link_data_oe,
  input wire logic       link_dir,
  input wire logic       link_nxt,
  input wire logic       core_reset_n,
  input wire logic       low_power_active,
  input wire logic       analog_power_enable,
  input wire logic       hs_transceiver_enable,
  input wire logic       fs_transceiver_enable,
  input wire logic       ls_transceiver_enable,
  input wire logic       tx_non_driving,
  input wire logic       tx_stuff_nrzi_enable,
  input wire logic       tx_auto_sync_eop,
  input wire logic       fs_pullup_enable,
  input wire logic       hs_termination_enable
);
  ////////////////////////////////////////////////////////////
  // Counts system cycles spent in core reset
  int low_cnt;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      low_cnt <= 0;
    else
      low_cnt <= core_reset_n ? 0 : low_cnt + 1;
  end

  // Read taken, and one aimed at an unmapped address
  sequence rd_taken;
    link_nxt && !link_dir && link_data_in[7:6] == 2'b11;
  endsequence
  sequence rd_other;
    rd_taken ##0 !(link_data_in[5:0] inside {6'h04, 6'h05, 6'h06});
  endsequence
  // Turn cycle, one data cycle, then the bus goes back
  sequence rd_answer;
    link_dir && !link_data_oe ##1 link_dir && link_data_oe ##1 !link_dir;
  endsequence

  a_read_turnaround: assert property (
    @(posedge clk_link) disable iff (!nrst) rd_taken |=> rd_answer)
    else $error("read answer out of step");
  a_unmapped_zero: assert property (
    @(posedge clk_link) disable iff (!nrst)
    rd_other |=> ##1 link_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_nxt_when_idle: assert property (
    @(posedge clk_link) disable iff (!nrst) link_nxt |-> !link_dir)
    else $error("command taken while device owns bus");
  a_reserved_zero: assert property (
    @(posedge clk_link) disable iff (!nrst)
    link_data_oe |-> !link_data_out[7])
    else $error("reserved bit driven high");
  a_core_reset_span: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(core_reset_n) |-> low_cnt == CORE_RESET_CYCLES)
    else $error("core reset span wrong");
  a_low_power_off: assert property (
    @(posedge clk_sys) disable iff (!nrst) low_power_active |->
    !analog_power_enable && !(hs_transceiver_enable
    || fs_transceiver_enable || ls_transceiver_enable))
    else $error("block left powered in low power");
  a_speed_exclusive: assert property (
    @(posedge clk_sys) disable iff (!nrst) $onehot0({hs_transceiver_enable,
    fs_transceiver_enable, ls_transceiver_enable}))
    else $error("two transceivers enabled");
  a_hs_term_speed: assert property (
    @(posedge clk_sys) disable iff (!nrst) hs_termination_enable |->
    hs_transceiver_enable && !fs_pullup_enable)
    else $error("termination against speed");
  a_encoding_exclusive: assert property (
    @(posedge clk_sys) disable iff (!nrst) tx_non_driving |->
    tx_stuff_nrzi_enable && tx_auto_sync_eop)
    else $error("encoding flags mixed");
  a_frame_exclusive: assert property (
    @(posedge clk_sys) disable iff (!nrst) !tx_auto_sync_eop |->
    tx_stuff_nrzi_enable && !tx_non_driving)
    else $error("framing flags mixed");
endmodule

bind upfc_function_control upfc_checker #(
  .CORE_RESET_CYCLES(CORE_RESET_CYCLES)
) i_upfc_checker (.*);

// File: tb/upfc_link_model.sv
`timescale 1ns/1ps

module upfc_link_model
  import upfc_pkg::*;
(
  input  wire logic       clk_link,
  input  wire logic       link_dir,
  input  wire logic       link_nxt,
  input  wire logic [7:0] link_data_out,
  output logic      [7:0] link_data_in,
  output logic            link_stp
);
  logic [7:0] drv = 8'h00;  // Byte the link puts on the bus
  initial link_stp = 1'b0;
  // Released while the device owns it: inverse, never a stale copy
  assign link_data_in = link_dir ? ~drv : drv;

  ////////////////////////////////////////////////////////////
  // Stay off the bus until direction is seen low at an edge
  task automatic wait_idle(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge clk_link);
      ok = (link_dir === 1'b0);
    end
    #1;
  endtask
  // Hold a command until the device takes it
  task automatic send_cmd(input logic [7:0] cmd, input int tries,
                          output bit ok);
    ok = 1'b0;
    drv = cmd;
    for (int n = 0; n < tries && !ok; n++) begin
      @(posedge clk_link);
      ok = (link_nxt === 1'b1);
    end
    #1;
  endtask
  // Command, data, then stop with the data still on the bus
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d,
                           output bit ok);
    wait_idle(ok);
    send_cmd({UPFC_CMD_REG_WR, a}, 20, ok);
    drv = d;
    @(posedge clk_link);
    #1 link_stp = 1'b1;
    @(posedge clk_link);
    #1 link_stp = 1'b0;
    drv = 8'h00;
  endtask
  // Command, turn cycle, then data sampled inside its cycle
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d,
                          output bit ok);
    wait_idle(ok);
    send_cmd({UPFC_CMD_REG_RD, a}, 20, ok);
    drv = 8'h00;
    @(posedge clk_link);
    #1 d = link_data_out;
  endtask
  // Stop pulse in idle brings the device out of low power
  task automatic wake();
    drv = 8'h00;
    link_stp = 1'b1;
    @(posedge clk_link);
    #1 link_stp = 1'b0;
  endtask
endmodule
